// [rtl/output_shutoff_consts.svh]
// offsets, field positions, reset values and counts of the shutoff block
`ifndef OUTPUT_SHUTOFF_CONSTS_SVH
`define OUTPUT_SHUTOFF_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFF_CTRL_A 8'h00
`define OFF_CTRL_B 8'h04
`define OFF_CTRL_C 8'h08
`define OFF_CTRL_D 8'h0c
`define OFF_CTRL_E 8'h10
`define OFF_OUT_CMP 8'h14
`define OFF_ACT_LVL 8'h18
`define OFF_SW_SHUT 8'h1c
`define OFF_CH0_PIN 8'h20
`define OFF_OSC 8'h24
`define OFF_HIZ_STAT 8'h28

// ****************************************************************
// field positions of the control/status words
// ****************************************************************
`define BIT_MODE_LO 0
`define BIT_MODE_HI 1
`define BIT_IRQ_EN 8
`define BIT_HIZ_EN 9
`define BIT_FLAG 12

// ****************************************************************
// reset values
// ****************************************************************
`define RST_CTRL 16'h0000
`define RST_ACT_LVL 6'h3f
`define RST_SW_SHUT 5'h00
`define RST_CH0_PIN 2'h0

// ****************************************************************
// sampling counts
// ****************************************************************
`define DIV_A 8'd8
`define DIV_B 8'd16
`define DIV_C 8'd128
`define SAMPLE_NUM 5'd16

`endif

// [rtl/output_shutoff_pkg.sv]
// types shared by the output shutoff block
package output_shutoff_pkg;
	typedef enum logic [1:0] {MODE_EDGE, MODE_DIV8, MODE_DIV16, MODE_DIV128}
		mode_type;
	typedef struct packed {
		logic flag;
		logic hiz_en;
		logic irq_en;
		mode_type mode;
	} ctrl_type;
	typedef struct packed {
		logic ch34_gen012;
		logic ch67;
		logic ch0_pin_a;
		logic ch0_pin_b;
		logic gen01;
		logic gen23;
	} hiz_type;
	typedef struct packed {
		logic ch34_gen012;
		logic ch67;
		logic ch0;
		logic gen01;
		logic gen23;
	} sw_type;
endpackage

// [rtl/output_shutoff_control.sv]
// emergency output shutoff control with a classic wishbone slave
//
// Functional notes
// - each request input: falling edge or 16 low samples at clk/8/16/128
// - five request inputs; a detection forces all timer output groups
// - oscillator stop detection can force all timer output groups
// - both outputs of a pair active one cycle forces paired groups
// - software enable bits force the timer output groups directly
// - interrupt on input detection and on output level comparison
// - each input has a two-bit mode field and a detection flag
// - a per-input interrupt enable gates that input's interrupt
// - a per-input hiz enable decides if detection forces outputs
// - separate software hiz bits per timer output group
// - each channel zero pin has its own hiz enable bit
`timescale 1ns/100ps
`include "output_shutoff_consts.svh"

module output_shutoff_control
	import output_shutoff_pkg::*;
#(
	parameter int INPUTS = 5,
	parameter int PAIRS = 6
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [INPUTS-1:0] shutdown_request_n_i,
	input wire logic osc_stop_i,
	input wire logic [PAIRS-1:0] pair_pos_i,
	input wire logic [PAIRS-1:0] pair_neg_i,
	output hiz_type hiz_o,
	output logic irq_o
);

	// ****************************************************************
	// helper functions
	// ****************************************************************
	function automatic logic div_tick(input mode_type m,
		input logic [7:0] c);
		logic t;
		t = 1'b0;
		case (m)
			MODE_DIV8: t = (c & (`DIV_A - 8'd1)) == (`DIV_A - 8'd1);
			MODE_DIV16: t = (c & (`DIV_B - 8'd1)) == (`DIV_B - 8'd1);
			MODE_DIV128: t = (c & (`DIV_C - 8'd1)) == (`DIV_C - 8'd1);
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	function automatic logic [15:0] ctrl_word(input ctrl_type c);
		logic [15:0] w;
		w = 16'h0000;
		w[`BIT_MODE_HI:`BIT_MODE_LO] = c.mode;
		w[`BIT_IRQ_EN] = c.irq_en;
		w[`BIT_HIZ_EN] = c.hiz_en;
		w[`BIT_FLAG] = c.flag;
		return w;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] wd, input logic [1:0] sel);
		logic [15:0] m;
		m = old;
		if (sel[0])
			m[7:0] = wd[7:0];
		if (sel[1])
			m[15:8] = wd[15:8];
		return m;
	endfunction

	// write of a control word: flag is cleared by writing zero once the
	// cause has gone, a set in the same cycle wins
	function automatic ctrl_type ctrl_write(input ctrl_type c,
		input logic [15:0] wd, input logic [1:0] sel, input logic gone);
		ctrl_type n;
		logic [15:0] m;
		n = c;
		m = merge16(ctrl_word(c), wd, sel);
		n.mode = mode_type'(m[`BIT_MODE_HI:`BIT_MODE_LO]);
		n.irq_en = m[`BIT_IRQ_EN];
		n.hiz_en = m[`BIT_HIZ_EN];
		if (sel[1] && !wd[`BIT_FLAG] && gone)
			n.flag = 1'b0;
		return n;
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	ctrl_type [INPUTS-1:0] in_ctrl_reg, in_ctrl_next;
	ctrl_type cmp_ctrl_reg, cmp_ctrl_next;
	ctrl_type osc_ctrl_reg, osc_ctrl_next;
	logic [PAIRS-1:0] act_lvl_reg, act_lvl_next;
	sw_type sw_reg, sw_next;
	logic [1:0] ch0_pin_reg, ch0_pin_next;
	logic [INPUTS-1:0][4:0] cnt_reg, cnt_next;
	logic [INPUTS-1:0] prev_reg, prev_next;
	logic [7:0] div_reg, div_next;
	logic [31:0] dat_reg, dat_next;
	logic ack_reg, ack_next;
	hiz_type hiz_reg, hiz_next;
	logic irq_reg, irq_next;

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb
	begin
		logic req;
		logic wr;
		logic [7:0] addr;
		logic [15:0] wd;
		logic [1:0] ws;
		logic low;
		logic hit;
		logic tick;
		logic [PAIRS-1:0] both;
		logic ext_any;
		logic cmp_any;
		logic ch0_force;
		low = 1'b0;
		hit = 1'b0;
		tick = 1'b0;
		ch0_force = 1'b0;
		in_ctrl_next = in_ctrl_reg;
		cmp_ctrl_next = cmp_ctrl_reg;
		osc_ctrl_next = osc_ctrl_reg;
		act_lvl_next = act_lvl_reg;
		sw_next = sw_reg;
		ch0_pin_next = ch0_pin_reg;
		cnt_next = cnt_reg;
		prev_next = shutdown_request_n_i;
		div_next = div_reg + 8'd1;
		dat_next = dat_reg;
		ack_next = 1'b0;
		req = cyc_i && stb_i && !ack_reg;
		wr = req && we_i;
		addr = {adr_i[7:2], 2'b00};
		wd = dat_i[15:0];
		ws = sel_i[1:0];
		both = ~(pair_pos_i ^ act_lvl_reg) & ~(pair_neg_i ^ act_lvl_reg);
		ext_any = 1'b0;
		cmp_any = 1'b0;
		irq_next = 1'b0;

		// bus writes to software-owned fields
		if (wr)
		begin
			case (addr)
				`OFF_CTRL_A, `OFF_CTRL_B, `OFF_CTRL_C, `OFF_CTRL_D,
				`OFF_CTRL_E:
				begin
					for (int i = 0; i < INPUTS; i++)
						if (addr == 8'(i * 4))
							in_ctrl_next[i] = ctrl_write(in_ctrl_reg[i],
								wd, ws, shutdown_request_n_i[i]);
				end
				`OFF_OUT_CMP: cmp_ctrl_next = ctrl_write(cmp_ctrl_reg, wd,
					ws, both == '0);
				`OFF_OSC: osc_ctrl_next = ctrl_write(osc_ctrl_reg, wd, ws,
					!osc_stop_i);
				`OFF_ACT_LVL:
				begin
					if (ws[0])
						act_lvl_next = wd[PAIRS-1:0];
				end
				`OFF_SW_SHUT:
				begin
					if (ws[0])
						sw_next = sw_type'(wd[4:0]);
				end
				`OFF_CH0_PIN:
				begin
					if (ws[0])
						ch0_pin_next = wd[1:0];
				end
				default: ;
			endcase
		end

		// request input detection, set wins over clear
		for (int i = 0; i < INPUTS; i++)
		begin
			low = !shutdown_request_n_i[i];
			hit = 1'b0;
			tick = div_tick(in_ctrl_reg[i].mode, div_reg);
			if (in_ctrl_reg[i].mode == MODE_EDGE)
			begin
				hit = prev_reg[i] && low;
				cnt_next[i] = 5'd0;
			end
			else if (tick)
			begin
				if (!low)
					cnt_next[i] = 5'd0;
				else if (cnt_reg[i] != `SAMPLE_NUM)
					cnt_next[i] = cnt_reg[i] + 5'd1;
				hit = low && (cnt_reg[i] >= `SAMPLE_NUM - 5'd1);
			end
			if (hit)
				in_ctrl_next[i].flag = 1'b1;
			if (in_ctrl_reg[i].flag && in_ctrl_reg[i].hiz_en)
				ext_any = 1'b1;
			if (in_ctrl_reg[i].flag && in_ctrl_reg[i].irq_en)
				irq_next = 1'b1;
		end

		// oscillator stop
		if (osc_stop_i)
			osc_ctrl_next.flag = 1'b1;
		if (osc_ctrl_reg.flag && osc_ctrl_reg.hiz_en)
			ext_any = 1'b1;

		// paired output comparison against the active level
		if (cmp_ctrl_reg.mode != MODE_EDGE && both != '0)
			cmp_ctrl_next.flag = 1'b1;
		if (cmp_ctrl_reg.flag && cmp_ctrl_reg.hiz_en)
			cmp_any = 1'b1;
		if (cmp_ctrl_reg.flag && cmp_ctrl_reg.irq_en)
			irq_next = 1'b1;

		// output forcing
		ch0_force = ext_any || sw_reg.ch0;
		hiz_next.ch34_gen012 = ext_any || cmp_any || sw_reg.ch34_gen012;
		hiz_next.ch67 = ext_any || cmp_any || sw_reg.ch67;
		hiz_next.gen01 = ext_any || cmp_any || sw_reg.gen01;
		hiz_next.gen23 = ext_any || cmp_any || sw_reg.gen23;
		hiz_next.ch0_pin_a = ch0_force && ch0_pin_reg[0];
		hiz_next.ch0_pin_b = ch0_force && ch0_pin_reg[1];

		// bus reads and acknowledge
		if (req)
		begin
			ack_next = 1'b1;
			dat_next = 32'h00000000;
			case (addr)
				`OFF_CTRL_A, `OFF_CTRL_B, `OFF_CTRL_C, `OFF_CTRL_D,
				`OFF_CTRL_E:
				begin
					for (int i = 0; i < INPUTS; i++)
						if (addr == 8'(i * 4))
							dat_next[15:0] = ctrl_word(in_ctrl_reg[i]);
				end
				`OFF_OUT_CMP: dat_next[15:0] = ctrl_word(cmp_ctrl_reg);
				`OFF_OSC: dat_next[15:0] = ctrl_word(osc_ctrl_reg);
				`OFF_ACT_LVL: dat_next[PAIRS-1:0] = act_lvl_reg;
				`OFF_SW_SHUT: dat_next[4:0] = sw_reg;
				`OFF_CH0_PIN: dat_next[1:0] = ch0_pin_reg;
				`OFF_HIZ_STAT: dat_next[5:0] = hiz_reg;
				default: dat_next = 32'h00000000;
			endcase
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < INPUTS; i++)
				in_ctrl_reg[i] <= ctrl_type'(5'h00);
			cmp_ctrl_reg <= ctrl_type'(5'h00);
			osc_ctrl_reg <= ctrl_type'(5'h00);
			act_lvl_reg <= `RST_ACT_LVL;
			sw_reg <= `RST_SW_SHUT;
			ch0_pin_reg <= `RST_CH0_PIN;
			cnt_reg <= '0;
			prev_reg <= '1;
			div_reg <= 8'h00;
			dat_reg <= 32'h00000000;
			ack_reg <= 1'b0;
			hiz_reg <= hiz_type'(6'h00);
			irq_reg <= 1'b0;
		end
		else
		begin
			in_ctrl_reg <= in_ctrl_next;
			cmp_ctrl_reg <= cmp_ctrl_next;
			osc_ctrl_reg <= osc_ctrl_next;
			act_lvl_reg <= act_lvl_next;
			sw_reg <= sw_next;
			ch0_pin_reg <= ch0_pin_next;
			cnt_reg <= cnt_next;
			prev_reg <= prev_next;
			div_reg <= div_next;
			dat_reg <= dat_next;
			ack_reg <= ack_next;
			hiz_reg <= hiz_next;
			irq_reg <= irq_next;
		end
	end

	assign dat_o = dat_reg;
	assign ack_o = ack_reg;
	assign hiz_o = hiz_reg;
	assign irq_o = irq_reg;

endmodule

// [dv/fault_source_model.sv]
// far-side model: request pins, oscillator monitor, paired timer outputs
`timescale 1ns/100ps
module fault_source_model
(
	input wire logic clk_i,
	input wire logic [17:0] cmd_i,
	output logic [17:0] pins_o
);
	// pins move only on the clock, as the timer outputs do
	always_ff @(posedge clk_i)
		pins_o <= cmd_i;
endmodule

// [dv/output_shutoff_control_props.sv]
// port assertions of the output shutoff block
`timescale 1ns/100ps
module output_shutoff_props
	import output_shutoff_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire hiz_type hiz_o,
	input wire logic irq_o
);
	logic [5:0] hiz_bits;
	assign hiz_bits = hiz_o;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ****
	// bus steps
	// ****
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_sw_write;
		s_req ##0 (we_i && adr_i[7:2] == 6'h07 && sel_i[0]);
	endsequence
	a_ack_pulse:
	assert property (ack_o |=> !ack_o) else $error("ack too long");
	a_ack_answer:
	assert property (s_req |=> ack_o) else $error("no ack");
	a_reset_quiet:
	assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o
		&& hiz_bits == 6'h00) else $error("outputs live in reset");
	a_upper_zero:
	assert property (dat_o[31:16] == 16'h0000) else $error("upper data");
	a_sw_force:
	assert property (s_sw_write ##0 (dat_i[4] && dat_i[0]) |=> ##1
		(hiz_o.ch34_gen012 && hiz_o.gen23)) else $error("sw force late");
	a_status_read:
	assert property (s_req ##0 (!we_i && adr_i[7:2] == 6'h0a) |=>
		dat_o[5:0] == $past(hiz_bits)) else $error("status read");
	a_unmapped_read:
	assert property (s_req ##0 (!we_i && adr_i[7:2] > 6'h0a) |=>
		dat_o == 32'h0) else $error("unmapped read");
	a_hiz_hold:
	assert property ((|($past(hiz_bits) & ~hiz_bits)) && !$past(rst_i)
		|-> $past(cyc_i && stb_i && we_i && !ack_o, 2))
		else $error("hiz dropped without write");
	a_irq_hold:
	assert property ($fell(irq_o) && !$past(rst_i)
		|-> $past(cyc_i && stb_i && we_i && !ack_o, 2))
		else $error("irq dropped without write");
endmodule
bind output_shutoff_control output_shutoff_props u_props
(
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
	.dat_o(dat_o), .ack_o(ack_o), .hiz_o(hiz_o), .irq_o(irq_o)
);

// [dv/testbench.sv]
// self-checking bench of the output shutoff block
`timescale 1ns/100ps
`include "output_shutoff_consts.svh"
module testbench;
	import output_shutoff_pkg::*;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
	logic we_i = 1'h0, osc = 1'h0;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0, rd, lfsr = 32'h7f8f;
	logic [4:0] req_n = 5'h1f;
	logic [5:0] pos = 6'h00, neg = 6'h00, r, b;
	wire [31:0] dat_o;
	wire ack_o, irq_o, osc_stop;
	wire [4:0] shut_n;
	wire [5:0] pp, pn;
	hiz_type hiz_o;
	int fails = 0, checks_done = 0, div;
	always #20 clk_i = ~clk_i;
	output_shutoff_control u_output_shutoff_control
	(
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(4'h3), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .shutdown_request_n_i(shut_n),
		.osc_stop_i(osc_stop), .pair_pos_i(pp), .pair_neg_i(pn),
		.hiz_o(hiz_o), .irq_o(irq_o)
	);
	fault_source_model u_fault_source_model
	(
		.clk_i(clk_i), .cmd_i({req_n, osc, pos, neg}),
		.pins_o({shut_n, osc_stop, pp, pn})
	);
	// ****
	// helpers
	// ****
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [5:0] exp_sw(input logic [4:0] s,
		input logic [1:0] p);
		return {s[4], s[3], s[2] & p[0], s[2] & p[1], s[1], s[0]};
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
		@(posedge clk_i);
		while (ack_o !== 1'b1)
			@(posedge clk_i);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'h0;
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_i);
		fails++;
		wrap_up;
	end
	// ****
	// tests
	// ****
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		wb(1'h0, `OFF_CTRL_A, 32'h0);
		chk(rd, 32'h0);
		wb(1'h0, `OFF_ACT_LVL, 32'h0);
		chk(rd, 32'h3f);
		wb(1'h1, 8'h2c, 32'hffff);
		wb(1'h0, 8'h2c, 32'h0);
		chk(rd, 32'h0);
		$display("reset and map test done");
		wb(1'h1, `OFF_CH0_PIN, 32'h1);
		for (int i = 0; i < 7; i++)
		begin
			r = (i == 5) ? 6'h1f : lfsr[5:0];
			if (i < 5)
				r = 6'h01 << i;
			lfsr = nxt(lfsr);
			wb(1'h1, `OFF_SW_SHUT, {27'h0, r[4:0]});
			tick(1);
			chk(hiz_o, exp_sw(r[4:0], 2'h1));
			wb(1'h0, `OFF_HIZ_STAT, 32'h0);
			chk(rd, exp_sw(r[4:0], 2'h1));
		end
		wb(1'h1, `OFF_SW_SHUT, 32'h0);
		wb(1'h1, `OFF_CH0_PIN, 32'h3);
		$display("software shutoff test done");
		wb(1'h1, `OFF_CTRL_A, 32'h300);
		req_n <= 5'h1e;
		tick(4);
		chk(hiz_o, 32'h3f);
		chk(irq_o, 32'h1);
		wb(1'h1, `OFF_CTRL_A, 32'h300);
		wb(1'h0, `OFF_CTRL_A, 32'h0);
		chk(rd, 32'h1300);
		req_n <= 5'h1f;
		wb(1'h1, `OFF_CTRL_A, 32'h300);
		tick(1);
		chk({hiz_o, irq_o}, 32'h0);
		wb(1'h1, `OFF_CTRL_E, 32'h0);
		req_n <= 5'h0f;
		tick(4);
		chk({hiz_o, irq_o}, 32'h0);
		wb(1'h0, `OFF_CTRL_E, 32'h0);
		chk(rd, 32'h1000);
		req_n <= 5'h1f;
		wb(1'h1, `OFF_CTRL_E, 32'h0);
		$display("edge detect test done");
		for (int m = 1; m < 4; m++)
		begin
			div = (m == 1) ? `DIV_A : (m == 2) ? `DIV_B : `DIV_C;
			wb(1'h1, `OFF_CTRL_C, 32'h200 | m);
			req_n <= 5'h1b;
			tick((`SAMPLE_NUM - 1) * div);
			chk(hiz_o, 32'h0);
			tick(div + 3);
			chk(hiz_o, 32'h3f);
			req_n <= 5'h1f;
			tick(div);
			wb(1'h1, `OFF_CTRL_C, 32'h0);
			tick(1);
			chk(hiz_o, 32'h0);
		end
		$display("level sampling test done");
		r = lfsr[5:0];
		lfsr = nxt(lfsr);
		b = 6'h01 << (lfsr[7:0] % 6);
		pos <= r;
		neg <= ~r;
		wb(1'h1, `OFF_OUT_CMP, 32'h301);
		pos <= r | b;
		neg <= ~r | b;
		tick(1);
		pos <= r;
		neg <= ~r;
		tick(3);
		chk({hiz_o, irq_o}, 32'h67);
		wb(1'h1, `OFF_OUT_CMP, 32'h301);
		tick(1);
		chk({hiz_o, irq_o}, 32'h0);
		$display("output compare test done");
		wb(1'h1, `OFF_OSC, 32'h200);
		osc <= 1'h1;
		tick(4);
		chk({hiz_o, irq_o}, 32'h7e);
		osc <= 1'h0;
		wb(1'h1, `OFF_OSC, 32'h0);
		tick(1);
		chk(hiz_o, 32'h0);
		$display("oscillator stop test done");
		wrap_up;
	end
endmodule
